// file: bwdt_pkg.sv
// Constants for the board watchdog timer: I/O map, fields and timing.
// Assumes a 40 MHz mclk and byte-wide host I/O cycles on that clock.
package bwdt_pkg;

  // I/O locations.
  localparam logic [9:0] ADDR_RETRIGGER = 10'h280;
  localparam logic [9:0] ADDR_PERIOD    = 10'h282;
  localparam logic [9:0] ADDR_ACTION    = 10'h284;

  // Period and arm register fields.
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 4;
  localparam int ARM_BIT      = 4;
  localparam int CAUSE_BIT    = 5;
  localparam logic [3:0] SEL_MAX = 4'hB;

  // Action register fields.
  localparam int ACT_RESET_BIT = 2;
  localparam int ACT_IRQ_BIT   = 6;
  localparam int ACT_NMI_BIT   = 7;

  // Reset values.
  localparam logic [3:0] SEL_RESET    = 4'h0;
  localparam logic [7:0] ACTION_RESET = 8'h00;

  // Timing: the shortest period, in ms, at the mclk rate in kHz.
  localparam int BASE_PERIOD_MS = 125;
  localparam int MCLK_KHZ       = 40000;
  localparam int BASE_CYCLES    = BASE_PERIOD_MS * MCLK_KHZ;
  localparam int PRESC_W        = 23;
  localparam int TICK_W         = 12;

endpackage

// file: bwdt_prescaler.sv
// Prescaler that gives one tick per shortest watchdog period.
// Assumes clear is a same-clock pulse that restarts the interval.
`timescale 1ns/1ps
`default_nettype none

module bwdt_prescaler #(
  parameter int BaseCycles = bwdt_pkg::BASE_CYCLES
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic reset,
  // Control.
  input  wire logic clear,
  output logic      tick
);

  localparam logic [bwdt_pkg::PRESC_W-1:0] LAST =
    bwdt_pkg::PRESC_W'(BaseCycles - 1);

  logic [bwdt_pkg::PRESC_W-1:0] count_q;

  always_ff @(posedge mclk) begin
    if (reset || clear || count_q == LAST) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_q == LAST);
    end
  end

endmodule

`default_nettype wire

// file: board_watchdog_timer.sv
// Board watchdog timer reached through three byte-wide I/O locations.
// Assumes host I/O strobes are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module board_watchdog_timer #(
  parameter int BaseCycles = bwdt_pkg::BASE_CYCLES
) (
  // Clock and power-on reset.
  input  wire logic       mclk,
  input  wire logic       reset,
  // Host I/O port.
  input  wire logic [9:0] ioAddr,
  input  wire logic       ioWr,
  input  wire logic       ioRd,
  input  wire logic [7:0] ioWrData,
  output logic      [7:0] ioRdData,
  // Expiry actions.
  output logic            sysResetOut,
  output logic            nmiOut,
  output logic            irqOut
);

  ////////////////////////////////////////////////////////////////////////
  // Decode and state.

  logic       wrRetrig, wrPeriod, wrAction;
  logic       tick, expire, restart;
  logic [3:0] sel_q;
  logic       arm_q, cause_q, stage2_q;
  logic [7:0] action_q;
  logic [bwdt_pkg::TICK_W-1:0] ticks_q;
  logic [bwdt_pkg::TICK_W-1:0] periodTicks;
  logic [3:0] selEff;
  logic       modeDual;

  assign wrRetrig = ioWr && ioAddr == bwdt_pkg::ADDR_RETRIGGER;
  assign wrPeriod = ioWr && ioAddr == bwdt_pkg::ADDR_PERIOD;
  assign wrAction = ioWr && ioAddr == bwdt_pkg::ADDR_ACTION;
  assign modeDual = action_q[bwdt_pkg::ACT_NMI_BIT]
                 && action_q[bwdt_pkg::ACT_RESET_BIT];

  // doubling periods
  // Reserved codes behave as the longest period.
  assign selEff = (sel_q > bwdt_pkg::SEL_MAX) ? bwdt_pkg::SEL_MAX : sel_q;
  assign periodTicks = bwdt_pkg::TICK_W'(1) << selEff;

  assign restart = !arm_q || wrRetrig || wrAction || expire;

  bwdt_prescaler #(
    .BaseCycles (BaseCycles)
  ) u_presc (
    .mclk  (mclk),
    .reset (reset),
    .clear (restart),
    .tick  (tick)
  );

  assign expire = arm_q && tick && (ticks_q + 1'b1 == periodTicks);

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge mclk) begin
    if (reset || sysResetOut) begin
      arm_q <= 1'b0;
    end else if (wrPeriod && ioWrData[bwdt_pkg::ARM_BIT]) begin
      arm_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || sysResetOut) begin
      sel_q <= bwdt_pkg::SEL_RESET;
    end else if (wrPeriod) begin
      sel_q <= ioWrData[bwdt_pkg::SEL_LSB +: bwdt_pkg::SEL_W];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || sysResetOut) begin
      action_q <= bwdt_pkg::ACTION_RESET;
    end else if (wrAction) begin
      action_q <= ioWrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cause_q <= 1'b0;
    end else if (sysResetOut) begin
      cause_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || restart) begin
      ticks_q <= '0;
    end else if (tick) begin
      ticks_q <= ticks_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Expiry actions.

  // rewrite cancels stage
  // An expiry in the same cycle as a host write still enters stage two.
  always_ff @(posedge mclk) begin
    if (reset || sysResetOut) begin
      stage2_q <= 1'b0;
    end else if (expire && modeDual && !stage2_q) begin
      stage2_q <= 1'b1;
    end else if (wrAction) begin
      stage2_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sysResetOut <= 1'b0;
    end else begin
      sysResetOut <= expire && action_q[bwdt_pkg::ACT_RESET_BIT]
                     && (!modeDual || stage2_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      nmiOut <= 1'b0;
    end else begin
      nmiOut <= expire && action_q[bwdt_pkg::ACT_NMI_BIT] && !stage2_q;
    end
  end

  // Interrupt is a level held until the host retriggers, rewrites the action register or sysResetOut fires.
  // A fresh expiry wins over a clear that falls in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset || sysResetOut) begin
      irqOut <= 1'b0;
    end else if (expire && action_q[bwdt_pkg::ACT_IRQ_BIT]) begin
      irqOut <= 1'b1;
    end else if (wrRetrig || wrAction) begin
      irqOut <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ioRdData <= 8'h00;
    end else if (ioRd && ioAddr == bwdt_pkg::ADDR_PERIOD) begin
      ioRdData <= {2'b00, cause_q, arm_q, sel_q};
    end else if (ioRd && ioAddr == bwdt_pkg::ADDR_ACTION) begin
      ioRdData <= action_q;
    end else if (ioRd) begin
      ioRdData <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_idle;
    @(posedge mclk) disable iff (reset)
      !arm_q |=> !sysResetOut && !nmiOut && !irqOut;
  endproperty
  a_idle: assert property (p_idle) else $error("action while disarmed");

  property p_sticky;
    @(posedge mclk) disable iff (reset)
      arm_q && !sysResetOut |=> arm_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("arm bit cleared");

  property p_retrig;
    @(posedge mclk) disable iff (reset)
      wrRetrig |=> ticks_q == '0 && !sysResetOut && !nmiOut;
  endproperty
  a_retrig: assert property (p_retrig) else $error("retrigger ignored");

  property p_plainReset;
    @(posedge mclk) disable iff (reset)
      expire && action_q[bwdt_pkg::ACT_RESET_BIT] && !modeDual
      |=> sysResetOut ##1 !arm_q && cause_q;
  endproperty
  a_plainReset: assert property (p_plainReset) else $error("no reset");

  property p_firstNmi;
    @(posedge mclk) disable iff (reset)
      expire && modeDual && !stage2_q |=> nmiOut && !sysResetOut && stage2_q;
  endproperty
  a_firstNmi: assert property (p_firstNmi) else $error("bad stage one");

  property p_second;
    @(posedge mclk) disable iff (reset)
      expire && modeDual && stage2_q |=> sysResetOut && !nmiOut;
  endproperty
  a_second: assert property (p_second) else $error("no stage two reset");

  property p_cause;
    @(posedge mclk) disable iff (reset)
      sysResetOut |=> cause_q [*2];
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag not set");

  property p_cancel;
    @(posedge mclk) disable iff (reset)
      wrAction && stage2_q |=> !stage2_q && ticks_q == '0;
  endproperty
  a_cancel: assert property (p_cancel) else $error("stage kept");

  property p_period;
    @(posedge mclk) disable iff (reset)
      (sel_q <= bwdt_pkg::SEL_MAX) ? periodTicks == (12'h001 << sel_q)
                                   : periodTicks == 12'h800;
  endproperty
  a_period: assert property (p_period) else $error("bad period");

  c_nmi:   cover property (@(posedge mclk) disable iff (reset) nmiOut);
  c_dual:  cover property (@(posedge mclk) disable iff (reset)
                           nmiOut ##[1:1000] sysResetOut);
  c_irq:   cover property (@(posedge mclk) disable iff (reset) irqOut);

endmodule

`default_nettype wire

// file: bwdt_testbench.sv
// Self-checking bench for the board watchdog timer.
// Assumes a short BaseCycles so that the shortest period is only ten cycles.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int Base = 10;
  logic       mclk;
  logic       reset;
  logic [9:0] ioAddr;
  logic       ioWr;
  logic       ioRd;
  logic [7:0] ioWrData;
  logic [7:0] ioRdData;
  logic       sysResetOut;
  logic       nmiOut;
  logic       irqOut;
  int         error_cnt;
  int         samples_checked;

  board_watchdog_timer #(.BaseCycles(Base)) dut (
    .mclk       (mclk),
    .reset      (reset),
    .ioAddr     (ioAddr),
    .ioWr       (ioWr),
    .ioRd       (ioRd),
    .ioWrData   (ioWrData),
    .ioRdData   (ioRdData),
    .sysResetOut(sysResetOut),
    .nmiOut     (nmiOut),
    .irqOut     (irqOut)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk);
    ioAddr   <= a;
    ioWrData <= d;
    ioWr     <= 1'b1;
    @(posedge mclk);
    ioWr     <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    ioAddr <= a;
    ioRd   <= 1'b1;
    @(posedge mclk);
    ioRd   <= 1'b0;
    @(negedge mclk);
    chk("read data", e, ioRdData);
  endtask

  // Waits for one action (0 reset, 1 NMI, 2 IRQ, -1 none) within lo..hi.
  task automatic expect_out(input int which, input int lo, input int hi);
    int         n;
    logic [2:0] v;
    n = 0;
    v = 3'b000;
    while (v == 3'b000 && n <= hi) begin
      @(negedge mclk);
      n++;
      v = {irqOut, nmiOut, sysResetOut};
    end
    chk("actions", (which < 0) ? 8'h00 : (8'h01 << which), {5'h00, v});
    if (which >= 0) begin
      chk("delay in range", 8'h01, {7'h00, (n >= lo && n <= hi)});
      if (n > hi) wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    rd(10'h282, 8'h00);
    rd(10'h284, 8'h00);
    rd(10'h280, 8'h00);
    rd(10'h286, 8'h00);
    wr(10'h284, 8'h04);
    expect_out(-1, 0, 80);
    $display("test idle done");
  endtask

  task automatic t_periods();
    int p;
    for (int s = 0; s < 5; s++) begin
      p = Base << s;
      wr(10'h284, 8'h04);
      wr(10'h282, 8'h10 | 8'(s));
      expect_out(0, p - 1, p + 3);
      rd(10'h282, 8'h20);
    end
    wr(10'h284, 8'h04);
    wr(10'h282, 8'h1C);
    rd(10'h282, 8'h3C);
    expect_out(0, 20477, 20483);
    rd(10'h282, 8'h20);
    $display("test periods done");
  endtask

  task automatic t_retrigger();
    wr(10'h284, 8'h04);
    wr(10'h282, 8'h11);
    for (int i = 0; i < 4; i++) begin
      expect_out(-1, 0, 12);
      wr(10'h280, 8'(i));
    end
    expect_out(0, 19, 23);
    $display("test retrigger done");
  endtask

  task automatic t_dual();
    wr(10'h284, 8'h84);
    wr(10'h282, 8'h10);
    expect_out(1, 9, 13);
    expect_out(0, 9, 13);
    $display("test dual done");
  endtask

  task automatic t_irq_sticky();
    wr(10'h284, 8'h40);
    wr(10'h282, 8'h12);
    wr(10'h282, 8'h02);
    rd(10'h282, 8'h32);
    expect_out(2, 28, 44);
    repeat (3) @(negedge mclk);
    chk("irq level", 8'h01, {7'h00, irqOut});
    wr(10'h280, 8'h00);
    @(negedge mclk);
    chk("irq cleared", 8'h00, {7'h00, irqOut});
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(10'h282, 8'h00);
    $display("test irq sticky done");
  endtask

  task automatic t_cancel();
    wr(10'h284, 8'h84);
    wr(10'h282, 8'h10);
    expect_out(1, 9, 13);
    wr(10'h284, 8'h84);
    expect_out(1, 8, 14);
    $display("test cancel done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    error_cnt       = 0;
    samples_checked = 0;
    reset           = 1'b1;
    ioAddr          = 10'h000;
    ioWr            = 1'b0;
    ioRd            = 1'b0;
    ioWrData        = 8'h00;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_idle();
    t_periods();
    t_retrigger();
    t_dual();
    t_irq_sticky();
    t_cancel();
    wrap_up();
  end
endmodule

`default_nettype wire
